// ---- mne_pkg.sv ----
// Constants and carrier types for the multiply/negate/idle execution block
package mne_pkg;

  // Opcode fields (upper seven bits, upper nibble or whole word)
  localparam logic [6:0]  OPC_MUL_FILE = 7'h01;
  localparam logic [6:0]  OPC_NEG_FILE = 7'h36;
  localparam logic [3:0]  OPC_IDLE_HI  = 4'hF;
  localparam logic [15:0] OPC_IDLE_ALL = 16'h0000;

  // Word field positions
  localparam int OPC_MSB  = 15;
  localparam int OPC_LSB  = 9;
  localparam int ACC_BIT  = 8;
  localparam int HI4_LSB  = 12;

  // Access bank split and indexed literal offset limit
  localparam logic [7:0]  ACC_LOW_MAX  = 8'h5F;
  localparam logic [3:0]  ACC_HI_PAGE  = 4'hF;
  localparam logic [7:0]  ILO_MAX      = 8'h5F;

  // Reset values and the negate compare constants
  localparam logic [15:0] PROD_RST     = 16'h0000;
  localparam logic [11:0] ADDR_RST     = 12'h000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [7:0]  NEG_MIN      = 8'h80;
  localparam logic [3:0]  NIB_ZERO     = 4'h0;

  // Execution states, one bit changing per step except the return from EXEC to IDLE
  typedef enum logic [1:0]
  {
    MNE_IDLE = 2'b00,
    MNE_READ = 2'b01,
    MNE_EXEC = 2'b11
  } mne_state_e;

  // Arithmetic status flags
  typedef struct packed
  {
    logic neg;
    logic signed_overflow_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } mne_flags_s;

  localparam mne_flags_s FLAGS_RST = '0;

  // Data memory request
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mne_mem_s;

  localparam mne_mem_s MEM_RST = '0;

endpackage

// ---- mne_exec.sv ----
// Execution datapath for file multiply, file negate and idle words
//
// How it works
// - File multiply stores the unsigned 16-bit W times f, high byte on top.
// - File multiply never writes W or the file register.
// - File multiply leaves every status flag untouched, zero result included.
// - Upper bits 0000 001 decode as file multiply with access bit and f.
// - Access bit 0 picks the access bank, 1 the bank pointer's bank.
// - Access bit 0, extended set on and f up to 5Fh: indexed offset mode.
// - File negate writes back the inverse of the operand plus one.
// - File negate sets negative, overflow, carry, half carry and zero.
// - Upper bits 0110 110 decode as file negate with access bit and f.
// - The all-zero word and any word with upper nibble 1111 change nothing.
`timescale 1ns/1ps
`default_nettype none

module mne_exec
  import mne_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [7:0]  w_i,
  input  wire logic [7:0]  bank_pointer_register_i,
  input  wire logic        ext_set_en_i,
  input  wire logic [11:0] index_base_i,
  input  wire logic [7:0]  mem_rdata_i,
  output var  mne_mem_s    mem_o,
  output var  mne_flags_s  flags_o,
  output logic [7:0]       product_high_byte_o,
  output logic [7:0]       product_low_byte_o,
  output logic             busy_o,
  output logic             done_o
);

  mne_state_e  state_q;
  mne_state_e  state_d;
  logic        is_neg_q;
  logic [7:0]  w_q;
  logic [15:0] prod_q;
  mne_flags_s  flags_q;
  mne_mem_s    mem_q;
  logic        done_q;
  logic        busy_q;

  // Two's complement of a byte
  function automatic logic [7:0] twos8(input logic [7:0] x);
    return 8'(~x + 8'h01);
  endfunction

  // Negate flags as the subtraction 0 - x
  function automatic mne_flags_s neg_flags(input logic [7:0] x);
    mne_flags_s f;
    logic [7:0] r;
    r = twos8(x);
    f.neg = r[7];
    f.signed_overflow_flag = (x == NEG_MIN);
    f.zero = (r == BYTE_RST);
    f.half_carry_flag = (x[3:0] == NIB_ZERO);
    f.carry = (x == BYTE_RST);
    return f;
  endfunction

  // Decoding
  wire [6:0]  opc      = instr_i[OPC_MSB:OPC_LSB];
  wire        acc_sel  = instr_i[ACC_BIT];
  wire [7:0]  faddr    = instr_i[7:0];
  wire        dec_mul  = (opc == OPC_MUL_FILE);
  wire        dec_neg  = (opc == OPC_NEG_FILE);
  wire        dec_idle = (instr_i == OPC_IDLE_ALL) ||
                         (instr_i[OPC_MSB:HI4_LSB] == OPC_IDLE_HI);
  wire        accept   = instr_valid_i && (state_q == MNE_IDLE);
  wire        start    = accept && (dec_mul || dec_neg);

  // Operand address selection
  // indexed literal offset
  wire        use_ilo  = !acc_sel && ext_set_en_i && (faddr <= ILO_MAX);
  wire [11:0] ilo_addr = 12'(index_base_i + {4'h0, faddr});
  wire [11:0] acc_addr = (faddr <= ACC_LOW_MAX) ? {4'h0, faddr}
                                                 : {ACC_HI_PAGE, faddr};
  wire [11:0] bnk_addr = {bank_pointer_register_i[3:0], faddr};
  wire [11:0] op_addr  = use_ilo ? ilo_addr
                       : (acc_sel ? bnk_addr : acc_addr);

  // Results
  // unsigned product
  wire [15:0] prod_new = {8'h00, w_q} * {8'h00, mem_rdata_i};
  wire [7:0]  neg_new  = twos8(mem_rdata_i);
  wire        in_exec  = (state_q == MNE_EXEC);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      MNE_IDLE: state_d = start ? MNE_READ : MNE_IDLE;
      MNE_READ: state_d = MNE_EXEC;
      MNE_EXEC: state_d = MNE_IDLE;
      default:  state_d = MNE_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q  <= MNE_IDLE;
      is_neg_q <= 1'b0;
      w_q      <= BYTE_RST;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      is_neg_q <= start ? dec_neg : is_neg_q;
      w_q      <= start ? w_i : w_q;
      done_q   <= in_exec || (accept && dec_idle);
      busy_q   <= (state_d != MNE_IDLE);
    end
  end

  // only the negate ever writes memory
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      mem_q <= MEM_RST;
    else
    begin
      mem_q.rd    <= start;
      mem_q.wr    <= in_exec && is_neg_q;
      mem_q.addr  <= start ? op_addr : mem_q.addr;
      mem_q.wdata <= (in_exec && is_neg_q) ? neg_new : mem_q.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prod_q  <= PROD_RST;
      flags_q <= FLAGS_RST;
    end
    else
    begin
      prod_q  <= (in_exec && !is_neg_q) ? prod_new : prod_q;
      flags_q <= (in_exec && is_neg_q) ? neg_flags(mem_rdata_i) : flags_q;
    end
  end

  assign mem_o               = mem_q;
  assign flags_o             = flags_q;
  assign product_high_byte_o = prod_q[15:8];
  assign product_low_byte_o  = prod_q[7:0];
  assign busy_o              = busy_q;
  assign done_o              = done_q;

  a_mul_product_value:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_mul) |-> ##3 (done_q && prod_q ==
        ({8'h00, $past(w_i, 3)} * {8'h00, $past(mem_rdata_i, 1)})))
    else $error("multiply product wrong");

  a_mul_no_write:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_mul) |-> ##1 (!mem_q.wr) [*3])
    else $error("multiply wrote memory");

  a_mul_flags_hold:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_mul) |-> ##3 (flags_q == $past(flags_q, 3)))
    else $error("multiply changed flags");

  a_mul_decode_read:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && instr_i[OPC_MSB:OPC_LSB] == OPC_MUL_FILE) |=>
        (mem_q.rd && busy_o))
    else $error("multiply not started");

  a_bank_address:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (start && acc_sel) |=>
        (mem_q.addr == {$past(bank_pointer_register_i[3:0]), $past(faddr)}))
    else $error("banked address wrong");

  a_ilo_address:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (start && !acc_sel && ext_set_en_i && faddr <= ILO_MAX) |=>
        (mem_q.addr == 12'($past(index_base_i) + {4'h0, $past(faddr)})))
    else $error("indexed address wrong");

  a_neg_writeback:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_neg) |-> ##3 (mem_q.wr &&
        mem_q.wdata == 8'(8'h00 - $past(mem_rdata_i, 1))))
    else $error("negate result wrong");

  a_neg_flags:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_neg) |-> ##3 ((flags_q.zero == flags_q.carry) &&
        (flags_q.zero == ($past(mem_rdata_i, 1) == BYTE_RST))))
    else $error("negate flags wrong");

  a_neg_decode_read:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && instr_i[OPC_MSB:OPC_LSB] == OPC_NEG_FILE) |=>
        (mem_q.rd && busy_o))
    else $error("negate not started");

  // sign, overflow and half carry follow the result
  a_neg_flag_bits:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_neg) |-> ##3 ((flags_q.neg == mem_q.wdata[7]) &&
        (flags_q.signed_overflow_flag == (mem_q.wdata == NEG_MIN)) &&
        (flags_q.half_carry_flag == (mem_q.wdata[3:0] == NIB_ZERO))))
    else $error("negate flag bits wrong");

  a_idle_no_change:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && dec_idle) |=> (done_q && !busy_o && !mem_q.wr && !mem_q.rd &&
        $stable(flags_q) && $stable(prod_q)))
    else $error("idle word had effect");

endmodule

`default_nettype wire

// ---- mne_exec_tb.sv ----
// Self-checking bench for the multiply/negate/idle execution block
`timescale 1ns/1ps
`default_nettype none

module testbench
  import mne_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic        instr_valid_i;
  logic [15:0] instr_i;
  logic [7:0]  w_i;
  logic [7:0]  bank_pointer_register_i;
  logic        ext_set_en_i;
  logic [11:0] index_base_i;
  logic [7:0]  mem_rdata_i;
  mne_mem_s    mem_o;
  mne_flags_s  flags_o;
  logic [7:0]  ph;
  logic [7:0]  pl;
  logic        busy_o;
  logic        done_o;
  int          mismatches;
  int          checked;
  // Multiply cases: word, W, operand, extended set, address
  logic [15:0] mw[5] = '{16'h03B5, 16'h0260, 16'h025F, 16'h0260, 16'h0205};
  logic [7:0]  mwv[5] = '{8'hC4, 8'h00, 8'hFF, 8'h01, 8'h10};
  logic [7:0]  mop[5] = '{8'hB5, 8'h77, 8'hFF, 8'h02, 8'h10};
  logic        mext[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [11:0] madr[5] = '{12'h3B5, 12'hF60, 12'h182, 12'hF60, 12'h005};
  logic [7:0]  nv[6] = '{8'h00, 8'h80, 8'h3A, 8'h10, 8'hFF, 8'h01};
  logic [15:0] iw[3] = '{16'h0000, 16'hF123, 16'hFFFF};

  mne_exec DUT (
    .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .w_i(w_i),
    .bank_pointer_register_i(bank_pointer_register_i),
    .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i),
    .mem_rdata_i(mem_rdata_i), .mem_o(mem_o), .flags_o(flags_o),
    .product_high_byte_o(ph), .product_low_byte_o(pl),
    .busy_o(busy_o), .done_o(done_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Zero minus operand, carries as not-borrow
  function automatic logic [15:0] nflags(input logic [7:0] x);
    logic [7:0] r;
    r = ~x + 8'h01;
    return {11'h000, r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0,
            x == 8'h00};
  endfunction

  // Offers one word, answers the read in the cycle after it, waits for done
  task automatic run(input logic [15:0] word, input logic [7:0] w,
                     input logic [7:0] op, output int lat,
                     output logic [11:0] adr, output logic wr,
                     output logic bsy);
    logic rd_seen;
    rd_seen = 1'b0;
    @(negedge clk_i);
    instr_i = word;
    w_i = w;
    instr_valid_i = 1'b1;
    mem_rdata_i = ~op;
    adr = 12'hFFF;
    @(posedge clk_i);
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    w_i = ~w;
    bsy = busy_o;
    lat = 1;
    while (done_o !== 1'b1 && lat < 8)
    begin
      mem_rdata_i = rd_seen ? op : ~op;
      rd_seen = (mem_o.rd === 1'b1);
      if (rd_seen)
        adr = mem_o.addr;
      @(negedge clk_i);
      lat++;
    end
    wr = mem_o.wr;
    mem_rdata_i = ~op;
  endtask

  initial
  begin
    #(1000 * 50);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    int          lat;
    logic [11:0] adr;
    logic        wr;
    logic        bsy;
    logic [15:0] prod;
    logic [15:0] fl;
    mismatches = 0;
    checked = 0;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    w_i = 8'h00;
    bank_pointer_register_i = 8'hA3;
    ext_set_en_i = 1'b0;
    index_base_i = 12'h123;
    mem_rdata_i = 8'h00;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    prod = 16'h0000;
    foreach (nv[i])
    begin
      run(16'h6C10, 8'h55, nv[i], lat, adr, wr, bsy);
      fl = nflags(nv[i]);
      chk(16'(lat), 16'h0003);
      chk({15'h0000, bsy}, 16'h0001);
      chk({4'h0, adr}, 16'h0010);
      chk({15'h0000, wr}, 16'h0001);
      chk({8'h00, mem_o.wdata}, {8'h00, ~nv[i] + 8'h01});
      chk({11'h000, flags_o}, fl);
      chk({ph, pl}, prod);
    end
    foreach (mw[i])
    begin
      ext_set_en_i = mext[i];
      run(mw[i], mwv[i], mop[i], lat, adr, wr, bsy);
      prod = 16'(mwv[i]) * 16'(mop[i]);
      chk(16'(lat), 16'h0003);
      chk({15'h0000, bsy}, 16'h0001);
      chk({ph, pl}, prod);
      chk({4'h0, adr}, {4'h0, madr[i]});
      chk({15'h0000, wr}, 16'h0000);
      chk({11'h000, flags_o}, fl);
    end
    foreach (iw[i])
    begin
      run(iw[i], 8'h99, 8'h42, lat, adr, wr, bsy);
      chk(16'(lat), 16'h0001);
      chk({15'h0000, bsy}, 16'h0000);
      chk({4'h0, adr}, 16'h0FFF);
      chk({15'h0000, wr}, 16'h0000);
      chk({ph, pl}, prod);
      chk({11'h000, flags_o}, fl);
    end
    // Word of another instruction: no read, no done, no effect
    run(16'h0E55, 8'h99, 8'h42, lat, adr, wr, bsy);
    chk(16'(lat), 16'h0008);
    chk({4'h0, adr}, 16'h0FFF);
    chk({15'h0000, wr}, 16'h0000);
    chk({ph, pl}, prod);
    chk({11'h000, flags_o}, fl);
    end_of_test();
  end
endmodule

`default_nettype wire
